/* inc/dtcp_pkg.sv */
// Shared constants and types for the dual timer/counter pair.
// Assumes an 8-bit register bus with single-cycle strobes.
package dtcp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RUN_FLAG = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_TA_LOW = 8'h8A;
  localparam logic [7:0] ADDR_TB_LOW = 8'h8B;
  localparam logic [7:0] ADDR_TA_HIGH = 8'h8C;
  localparam logic [7:0] ADDR_TB_HIGH = 8'h8D;
  localparam logic [7:0] ADDR_CLK_DIV = 8'h8E;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hA0;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hA1;

  // ----------------------------------------------------------------
  // Reset values and counting constants
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_CLK_DIV = 8'h01;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [4:0] LOW5_MAX = 5'h1F;
  localparam logic [4:0] LOW5_ONE = 5'h01;
  localparam logic [3:0] DIV_LAST = 4'hB;
  localparam logic [3:0] DIV_FAST_MASK = 4'h3;
  localparam logic [3:0] DIV_ZERO = 4'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TF_B = 7;
  localparam int TR_B = 6;
  localparam int TF_A = 5;
  localparam int TR_A = 4;
  localparam int IE_B = 3;
  localparam int IT_B = 2;
  localparam int IE_A = 1;
  localparam int IT_A = 0;
  localparam int GATE_B = 7;
  localparam int CT_B = 6;
  localparam int MODE_B_LSB = 4;
  localparam int GATE_A = 3;
  localparam int CT_A = 2;
  localparam int MODE_A_LSB = 0;
  localparam int FAST_B = 4;
  localparam int FAST_A = 3;
  localparam int EV_TA = 0;
  localparam int EV_TB = 1;
  localparam int EV_XA = 2;
  localparam int EV_XB = 3;
  localparam int NUM_EV = 4;
  localparam int PIN_CNT_A = 0;
  localparam int PIN_CNT_B = 1;
  localparam int PIN_IRQ_A = 2;
  localparam int PIN_IRQ_B = 3;
  localparam int NUM_PINS = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_13 = 2'b00,
    MODE_16 = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } dtcp_mode_e;

  typedef struct packed {
    logic [7:0] timer_run_flag_control;
    logic [7:0] timer_mode_select;
    logic [7:0] tl0;
    logic [7:0] tl1;
    logic [7:0] th0;
    logic [7:0] th1;
    logic [7:0] clock_divider_control;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] mask;
    logic [7:0] rdata;
    logic irq;
  } dtcp_state_s;

  typedef struct packed {
    logic [3:0] cnt;
    logic tick_a;
    logic tick_b;
  } dtcp_tick_s;

  typedef struct packed {
    logic [NUM_PINS-1:0] prev;
    logic [NUM_PINS-1:0] fall;
  } dtcp_edge_s;

endpackage : dtcp_pkg

/* inc/dtcp_pin_if.sv */
// Pin group between the timer core and its falling-edge detector.
// Assumes pins are synchronous to the block clock.
`timescale 1ns/10ps
interface dtcp_pin_if;
  logic [dtcp_pkg::NUM_PINS-1:0] pin;
  logic [dtcp_pkg::NUM_PINS-1:0] fall;
  modport det (input pin, output fall);
  modport user (output pin, input fall);
endinterface : dtcp_pin_if

/* rtl/dtcp_tick_gen.sv */
// Internal count tick generator: divide by 12, or by 4 when fast.
// Assumes a free-running clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module dtcp_tick_gen (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic fast_a,
  input wire logic fast_b,
  output logic tick_a,
  output logic tick_b
);
  dtcp_pkg::dtcp_tick_s st;
  dtcp_pkg::dtcp_tick_s next_st;
  logic slow;
  logic fast;

  always_comb begin
    next_st = st;
    slow = (st.cnt == dtcp_pkg::DIV_ZERO);
    fast = ((st.cnt & dtcp_pkg::DIV_FAST_MASK) == dtcp_pkg::DIV_ZERO);
    if (st.cnt == dtcp_pkg::DIV_LAST) begin
      next_st.cnt = dtcp_pkg::DIV_ZERO;
    end else begin
      next_st.cnt = st.cnt + 4'h1;
    end
    next_st.tick_a = fast_a ? fast : slow;
    next_st.tick_b = fast_b ? fast : slow;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_a = st.tick_a;
  assign tick_b = st.tick_b;
endmodule : dtcp_tick_gen

/* rtl/dtcp_edge_det.sv */
// Falling-edge detector for the count and interrupt pins.
// Assumes pins are synchronous and idle high.
`timescale 1ns/10ps
module dtcp_edge_det (
  input wire logic clk,
  input wire logic arst_n,
  dtcp_pin_if.det p
);
  dtcp_pkg::dtcp_edge_s st;
  dtcp_pkg::dtcp_edge_s next_st;
  logic [dtcp_pkg::NUM_PINS-1:0] fall_w;

  for (genvar i = 0; i < dtcp_pkg::NUM_PINS; i++) begin : g_pin
    assign fall_w[i] = st.prev[i] & ~p.pin[i];
  end

  always_comb begin
    next_st = st;
    next_st.prev = p.pin;
    next_st.fall = fall_w;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= {{dtcp_pkg::NUM_PINS{1'b1}}, {dtcp_pkg::NUM_PINS{1'b0}}};
    end else begin
      st <= next_st;
    end
  end

  assign p.fall = st.fall;
endmodule : dtcp_edge_det

/* rtl/dtcp_timer_pair.sv */
// Two timer/counters with run, gate, source and mode control, plus
// external interrupt detect flags and a masked interrupt output.
// Assumes a register master with one-cycle strobes; pins synchronous.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
module dtcp_timer_pair (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [3:0] vec_ack,
  input wire logic timer_a_count_pin,
  input wire logic timer_b_count_pin,
  input wire logic ext_irq_a_pin,
  input wire logic ext_irq_b_pin,
  output logic [7:0] rdata,
  output logic irq,
  output logic [3:0] int_req
);

  // ----------------------------------------------------------------
  // Count step
  // ----------------------------------------------------------------
  // Returns {overflow, high, low} after one count in the given mode.
  function automatic logic [16:0] dtcp_step(
    input dtcp_pkg::dtcp_mode_e mode,
    input logic [7:0] hi,
    input logic [7:0] lo
  );
    logic ovf;
    logic [7:0] nhi;
    logic [7:0] nlo;
    ovf = 1'b0;
    nhi = hi;
    nlo = lo;
    unique case (mode)
      dtcp_pkg::MODE_13: begin
        nlo = {lo[7:5], lo[4:0] + dtcp_pkg::LOW5_ONE};
        if (lo[4:0] == dtcp_pkg::LOW5_MAX) begin
          nhi = hi + dtcp_pkg::BYTE_ONE;
          ovf = (hi == dtcp_pkg::BYTE_MAX);
        end
      end
      dtcp_pkg::MODE_16: begin
        nlo = lo + dtcp_pkg::BYTE_ONE;
        if (lo == dtcp_pkg::BYTE_MAX) begin
          nhi = hi + dtcp_pkg::BYTE_ONE;
          ovf = (hi == dtcp_pkg::BYTE_MAX);
        end
      end
      dtcp_pkg::MODE_RELOAD: begin
        if (lo == dtcp_pkg::BYTE_MAX) begin
          nlo = hi;
          ovf = 1'b1;
        end else begin
          nlo = lo + dtcp_pkg::BYTE_ONE;
        end
      end
      dtcp_pkg::MODE_SPLIT: begin
        nlo = lo + dtcp_pkg::BYTE_ONE;
        ovf = (lo == dtcp_pkg::BYTE_MAX);
      end
    endcase
    return {ovf, nhi, nlo};
  endfunction : dtcp_step

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  dtcp_pkg::dtcp_state_s st;
  dtcp_pkg::dtcp_state_s next_st;
  dtcp_pkg::dtcp_mode_e mode_a;
  dtcp_pkg::dtcp_mode_e mode_b;
  logic tick_a;
  logic tick_b;
  logic split;
  logic wr_timer_run_flag_control;
  logic wr_cnt_a;
  logic wr_cnt_b;
  logic rd_status;
  logic run_a;
  logic run_b;
  logic inc_a;
  logic inc_ah;
  logic inc_b;
  logic [16:0] step_a;
  logic [16:0] step_ah;
  logic [16:0] step_b;
  logic set_tf_a;
  logic set_tf_b;
  logic [dtcp_pkg::NUM_EV-1:0] events;

  dtcp_pin_if pins ();

  assign pins.pin = {ext_irq_b_pin, ext_irq_a_pin,
                     timer_b_count_pin, timer_a_count_pin};

  dtcp_edge_det u_edge (
    .clk(clk),
    .arst_n(arst_n),
    .p(pins.det)
  );

  dtcp_tick_gen u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .fast_a(st.clock_divider_control[dtcp_pkg::FAST_A]),
    .fast_b(st.clock_divider_control[dtcp_pkg::FAST_B]),
    .tick_a(tick_a),
    .tick_b(tick_b)
  );

  // ----------------------------------------------------------------
  // Count enables
  // ----------------------------------------------------------------
  assign mode_a = dtcp_pkg::dtcp_mode_e'(st.timer_mode_select[dtcp_pkg::MODE_A_LSB +: 2]);
  assign mode_b = dtcp_pkg::dtcp_mode_e'(st.timer_mode_select[dtcp_pkg::MODE_B_LSB +: 2]);
  assign split = (mode_a == dtcp_pkg::MODE_SPLIT);
  assign wr_timer_run_flag_control = wr && (addr == dtcp_pkg::ADDR_RUN_FLAG);
  assign wr_cnt_a = wr && (addr == dtcp_pkg::ADDR_TA_LOW ||
                           addr == dtcp_pkg::ADDR_TA_HIGH);
  assign wr_cnt_b = wr && (addr == dtcp_pkg::ADDR_TB_LOW ||
                           addr == dtcp_pkg::ADDR_TB_HIGH);
  assign rd_status = rd && (addr == dtcp_pkg::ADDR_IRQ_STATUS);

  // Gate lets the interrupt pin hold off counting while it is low.
  assign run_a = st.timer_run_flag_control[dtcp_pkg::TR_A] &&
                 (!st.timer_mode_select[dtcp_pkg::GATE_A] || ext_irq_a_pin);
  assign inc_a = run_a && (st.timer_mode_select[dtcp_pkg::CT_A] ?
                 pins.fall[dtcp_pkg::PIN_CNT_A] : tick_a);
  // The high byte of a split timer A borrows timer B's run bit.
  assign inc_ah = split && st.timer_run_flag_control[dtcp_pkg::TR_B] && tick_a;
  assign run_b = (split || st.timer_run_flag_control[dtcp_pkg::TR_B]) &&
                 (!st.timer_mode_select[dtcp_pkg::GATE_B] || ext_irq_b_pin);
  assign inc_b = run_b && (mode_b != dtcp_pkg::MODE_SPLIT) &&
                 (st.timer_mode_select[dtcp_pkg::CT_B] ?
                 pins.fall[dtcp_pkg::PIN_CNT_B] : tick_b);

  assign step_a = dtcp_step(split ? dtcp_pkg::MODE_SPLIT : mode_a,
                            st.th0, st.tl0);
  assign step_ah = dtcp_step(dtcp_pkg::MODE_SPLIT, dtcp_pkg::RST_BYTE,
                             st.th0);
  assign step_b = dtcp_step(mode_b, st.th1, st.tl1);
  assign set_tf_a = inc_a && step_a[16];
  // Timer B loses its flag to the split high byte.
  assign set_tf_b = split ? (inc_ah && step_ah[16])
                          : (inc_b && step_b[16]);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (inc_a) begin
      next_st.tl0 = step_a[7:0];
      if (!split) begin
        next_st.th0 = step_a[15:8];
      end
    end
    if (inc_ah) begin
      next_st.th0 = step_ah[7:0];
    end
    if (inc_b) begin
      next_st.tl1 = step_b[7:0];
      next_st.th1 = step_b[15:8];
    end
    // Software writes to a count byte win over a count in that cycle.
    if (wr) begin
      case (addr)
        dtcp_pkg::ADDR_RUN_FLAG: next_st.timer_run_flag_control = wdata;
        dtcp_pkg::ADDR_MODE: next_st.timer_mode_select = wdata;
        dtcp_pkg::ADDR_TA_LOW: next_st.tl0 = wdata;
        dtcp_pkg::ADDR_TB_LOW: next_st.tl1 = wdata;
        dtcp_pkg::ADDR_TA_HIGH: next_st.th0 = wdata;
        dtcp_pkg::ADDR_TB_HIGH: next_st.th1 = wdata;
        dtcp_pkg::ADDR_CLK_DIV: next_st.clock_divider_control = wdata;
        dtcp_pkg::ADDR_IRQ_MASK: begin
          next_st.mask = wdata[dtcp_pkg::NUM_EV-1:0];
        end
        default: next_st.timer_run_flag_control = st.timer_run_flag_control;
      endcase
    end
    // Hardware sets win over software or vector clears.
    next_st.timer_run_flag_control[dtcp_pkg::TF_A] = (wr_timer_run_flag_control ? wdata[dtcp_pkg::TF_A] :
      st.timer_run_flag_control[dtcp_pkg::TF_A] && !vec_ack[dtcp_pkg::EV_TA]) ||
      set_tf_a;
    next_st.timer_run_flag_control[dtcp_pkg::TF_B] = (wr_timer_run_flag_control ? wdata[dtcp_pkg::TF_B] :
      st.timer_run_flag_control[dtcp_pkg::TF_B] && !vec_ack[dtcp_pkg::EV_TB]) ||
      set_tf_b;
    if (st.timer_run_flag_control[dtcp_pkg::IT_A]) begin
      next_st.timer_run_flag_control[dtcp_pkg::IE_A] = (wr_timer_run_flag_control ? wdata[dtcp_pkg::IE_A] :
        st.timer_run_flag_control[dtcp_pkg::IE_A] && !vec_ack[dtcp_pkg::EV_XA]) ||
        pins.fall[dtcp_pkg::PIN_IRQ_A];
    end else begin
      next_st.timer_run_flag_control[dtcp_pkg::IE_A] = !ext_irq_a_pin;
    end
    if (st.timer_run_flag_control[dtcp_pkg::IT_B]) begin
      next_st.timer_run_flag_control[dtcp_pkg::IE_B] = (wr_timer_run_flag_control ? wdata[dtcp_pkg::IE_B] :
        st.timer_run_flag_control[dtcp_pkg::IE_B] && !vec_ack[dtcp_pkg::EV_XB]) ||
        pins.fall[dtcp_pkg::PIN_IRQ_B];
    end else begin
      next_st.timer_run_flag_control[dtcp_pkg::IE_B] = !ext_irq_b_pin;
    end
    events = {next_st.timer_run_flag_control[dtcp_pkg::IE_B] && !st.timer_run_flag_control[dtcp_pkg::IE_B],
              next_st.timer_run_flag_control[dtcp_pkg::IE_A] && !st.timer_run_flag_control[dtcp_pkg::IE_A],
              set_tf_b, set_tf_a};
    // Reading the status clears it; an event in that cycle survives.
    next_st.status = (rd_status ? '0 : st.status) | events;
    next_st.irq = |(next_st.status & next_st.mask);
    next_st.rdata = dtcp_pkg::RST_BYTE;
    if (rd) begin
      case (addr)
        dtcp_pkg::ADDR_RUN_FLAG: next_st.rdata = st.timer_run_flag_control;
        dtcp_pkg::ADDR_MODE: next_st.rdata = st.timer_mode_select;
        dtcp_pkg::ADDR_TA_LOW: next_st.rdata = st.tl0;
        dtcp_pkg::ADDR_TB_LOW: next_st.rdata = st.tl1;
        dtcp_pkg::ADDR_TA_HIGH: next_st.rdata = st.th0;
        dtcp_pkg::ADDR_TB_HIGH: next_st.rdata = st.th1;
        dtcp_pkg::ADDR_CLK_DIV: next_st.rdata = st.clock_divider_control;
        dtcp_pkg::ADDR_IRQ_STATUS: next_st.rdata = {4'h0, st.status};
        dtcp_pkg::ADDR_IRQ_MASK: next_st.rdata = {4'h0, st.mask};
        default: next_st.rdata = dtcp_pkg::RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{timer_run_flag_control: dtcp_pkg::RST_BYTE, timer_mode_select: dtcp_pkg::RST_BYTE,
              tl0: dtcp_pkg::RST_BYTE, tl1: dtcp_pkg::RST_BYTE,
              th0: dtcp_pkg::RST_BYTE, th1: dtcp_pkg::RST_BYTE,
              clock_divider_control: dtcp_pkg::RST_CLK_DIV, status: '0, mask: '0,
              rdata: dtcp_pkg::RST_BYTE, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq = st.irq;
  assign int_req = {st.timer_run_flag_control[dtcp_pkg::IE_B], st.timer_run_flag_control[dtcp_pkg::IE_A],
                    st.timer_run_flag_control[dtcp_pkg::TF_B], st.timer_run_flag_control[dtcp_pkg::TF_A]};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_tf_b_sticky;
    st.timer_run_flag_control[dtcp_pkg::TF_B] && !wr_timer_run_flag_control && !vec_ack[dtcp_pkg::EV_TB]
      |=> st.timer_run_flag_control[dtcp_pkg::TF_B];
  endproperty
  a_tf_b_sticky: assert property (p_tf_b_sticky)
    else $error("Timer B overflow flag dropped on its own.");

  property p_tf_a_set;
    inc_a && step_a[16] |=> st.timer_run_flag_control[dtcp_pkg::TF_A] && st.status[0];
  endproperty
  a_tf_a_set: assert property (p_tf_a_set)
    else $error("Timer A rollover did not set its flag.");

  property p_vec_clear;
    st.timer_run_flag_control[dtcp_pkg::TF_A] && vec_ack[dtcp_pkg::EV_TA] && !wr_timer_run_flag_control &&
      !set_tf_a |=> !st.timer_run_flag_control[dtcp_pkg::TF_A];
  endproperty
  a_vec_clear: assert property (p_vec_clear)
    else $error("Vectoring did not clear the timer A flag.");

  property p_halt;
    !st.timer_run_flag_control[dtcp_pkg::TR_A] && !split && !wr_cnt_a
      |=> $stable(st.tl0) && $stable(st.th0);
  endproperty
  a_halt: assert property (p_halt)
    else $error("Halted timer A changed its count.");

  property p_gate;
    st.timer_mode_select[dtcp_pkg::GATE_A] && !ext_irq_a_pin && !split && !wr_cnt_a
      |=> $stable({st.th0, st.tl0});
  endproperty
  a_gate: assert property (p_gate)
    else $error("Gated timer A counted with its pin low.");

  property p_source;
    st.timer_run_flag_control[dtcp_pkg::TR_A] && !st.timer_mode_select[dtcp_pkg::GATE_A] &&
      st.timer_mode_select[dtcp_pkg::CT_A] && !pins.fall[dtcp_pkg::PIN_CNT_A] &&
      !split && !wr_cnt_a |=> $stable({st.th0, st.tl0});
  endproperty
  a_source: assert property (p_source)
    else $error("Counter mode advanced without a pin pulse.");

  property p_mode16;
    mode_a == dtcp_pkg::MODE_16 && inc_a && !wr_cnt_a &&
      st.tl0 == dtcp_pkg::BYTE_MAX && st.th0 != dtcp_pkg::BYTE_MAX
      |=> st.th0 == $past(st.th0) + dtcp_pkg::BYTE_ONE && st.tl0 == '0;
  endproperty
  a_mode16: assert property (p_mode16)
    else $error("Sixteen-bit carry into the high byte failed.");

  property p_b_halt;
    mode_b == dtcp_pkg::MODE_SPLIT && !wr_cnt_b
      |=> $stable(st.tl1) && $stable(st.th1);
  endproperty
  a_b_halt: assert property (p_b_halt)
    else $error("Timer B counted in its halting mode.");

  property p_split_high;
    split && st.timer_run_flag_control[dtcp_pkg::TR_B] && tick_a && !wr_cnt_a &&
      st.th0 == dtcp_pkg::BYTE_MAX |=> st.timer_run_flag_control[dtcp_pkg::TF_B] &&
      st.th0 == '0;
  endproperty
  a_split_high: assert property (p_split_high)
    else $error("Split high byte did not roll into the B flag.");

  property p_b_split_run;
    split && mode_b == dtcp_pkg::MODE_16 && !st.timer_run_flag_control[dtcp_pkg::TR_B] &&
      !st.timer_mode_select[dtcp_pkg::GATE_B] && !wr_cnt_b &&
      (st.timer_mode_select[dtcp_pkg::CT_B] ? pins.fall[dtcp_pkg::PIN_CNT_B] : tick_b)
      |=> st.tl1 != $past(st.tl1);
  endproperty
  a_b_split_run: assert property (p_b_split_run)
    else $error("Timer B did not run during split mode.");

  property p_write_low;
    wr && addr == dtcp_pkg::ADDR_TA_LOW
      |=> st.tl0 == $past(wdata) ##1 rd && addr == dtcp_pkg::ADDR_TA_LOW &&
      !inc_a |=> rdata == $past(st.tl0, 1);
  endproperty
  a_write_low: assert property (p_write_low)
    else $error("Count low byte did not take the written value.");

  property p_level;
    !st.timer_run_flag_control[dtcp_pkg::IT_A]
      |=> st.timer_run_flag_control[dtcp_pkg::IE_A] == !$past(ext_irq_a_pin);
  endproperty
  a_level: assert property (p_level)
    else $error("Level detect flag did not follow the pin.");

  property p_reload;
    mode_a == dtcp_pkg::MODE_RELOAD && inc_a && !wr_cnt_a &&
      st.tl0 == dtcp_pkg::BYTE_MAX |=> st.tl0 == $past(st.th0) &&
      $stable(st.th0);
  endproperty
  a_reload: assert property (p_reload)
    else $error("Reload mode did not reload the low byte.");

  property p_prescale;
    mode_a == dtcp_pkg::MODE_13 && inc_a && !wr_cnt_a &&
      st.tl0[4:0] != dtcp_pkg::LOW5_MAX |=> $stable(st.th0);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("Prescaler carried before reaching its top.");

  property p_irq_level;
    st.status[dtcp_pkg::EV_TA] && st.mask[dtcp_pkg::EV_TA] && !rd_status &&
      !(wr && addr == dtcp_pkg::ADDR_IRQ_MASK) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Unmasked status did not hold the interrupt.");

  cover property (set_tf_a ##[1:20] vec_ack[dtcp_pkg::EV_TA]);
  cover property (split && inc_ah && step_ah[16]);
  cover property (mode_a == dtcp_pkg::MODE_RELOAD && set_tf_a);
  cover property (st.timer_run_flag_control[dtcp_pkg::IT_B] &&
                  pins.fall[dtcp_pkg::PIN_IRQ_B] ##1 irq);

endmodule : dtcp_timer_pair

/* test/dtcp_cpu_model.sv */
// Processor-side model: drives register strobes and vector acknowledges.
// Assumes the timer block answers a read in the following cycle only.
`timescale 1ns/10ps
module dtcp_cpu_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  output logic [3:0] vec_ack
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    vec_ack = 4'h0;
  end

  // Released lines show the inverse so stale values never look valid.
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : put

  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask : get

  task automatic ack(input int i);
    @(posedge clk);
    vec_ack[i] <= 1'b1;
    @(posedge clk);
    vec_ack <= 4'h0;
  endtask : ack
endmodule : dtcp_cpu_model

/* test/tb_top.sv */
// Self-checking bench for the timer pair, one task per scenario.
// Assumes the processor model drives the register port and acks.
`timescale 1ns/10ps
module tb_top;
  localparam int LIMIT = 10000;
  logic clk;
  logic arst_n;
  logic [3:0] pins;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [3:0] vec_ack;
  logic [7:0] rdata;
  logic irq;
  logic [3:0] int_req;
  logic [7:0] rv;
  int fails = 0;
  int checks = 0;
  int cyc = 0;

  dtcp_cpu_model cpu (.clk(clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .vec_ack(vec_ack));
  dtcp_timer_pair DUT (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .vec_ack(vec_ack),
    .timer_a_count_pin(pins[0]), .timer_b_count_pin(pins[1]),
    .ext_irq_a_pin(pins[2]), .ext_irq_b_pin(pins[3]),
    .rdata(rdata), .irq(irq), .int_req(int_req));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t byte got %h expected %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t bit got %b expected %b", $time, g, e);
    end
  endtask : chk1

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    cpu.get(a, rv);
    chk8(rv, e);
  endtask : rchk

  task automatic rbit(input logic [7:0] a, input int b, input logic e);
    cpu.get(a, rv);
    chk1(rv[b], e);
  endtask : rbit

  task automatic pulse(input int i);
    @(posedge clk);
    pins[i] <= 1'b0;
    @(posedge clk);
    pins[i] <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      rchk(8'h88 + 8'(i), 8'h00);
    end
    rchk(8'h8E, 8'h01);
    rchk(8'hA0, 8'h00);
    rchk(8'h90, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_rw;
    for (int i = 0; i < 4; i++) begin
      cpu.put(8'h8A + 8'(i), 8'hA5 ^ 8'(i * 17));
    end
    cpu.put(8'h90, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      rchk(8'h8A + 8'(i), 8'hA5 ^ 8'(i * 17));
    end
    rchk(8'h90, 8'h00);
    $display("test rw done");
  endtask : t_rw

  task automatic t_run_gate;
    cpu.put(8'h89, 8'h05);
    cpu.put(8'h8A, 8'hFE);
    rchk(8'h8A, 8'hFE);
    cpu.put(8'h8C, 8'h00);
    cpu.put(8'h88, 8'h10);
    repeat (3) pulse(0);
    rchk(8'h8A, 8'h01);
    rchk(8'h8C, 8'h01);
    cpu.put(8'h88, 8'h00);
    repeat (2) pulse(0);
    rchk(8'h8A, 8'h01);
    cpu.put(8'h89, 8'h0D);
    cpu.put(8'h88, 8'h10);
    @(posedge clk);
    pins[2] <= 1'b0;
    repeat (2) pulse(0);
    rchk(8'h8A, 8'h01);
    pins[2] <= 1'b1;
    pulse(0);
    rchk(8'h8A, 8'h02);
    $display("test run_gate done");
  endtask : t_run_gate

  task automatic t_ovf;
    cpu.put(8'h88, 8'h00);
    cpu.put(8'hA1, 8'h01);
    cpu.get(8'hA0, rv);
    cpu.put(8'h89, 8'h05);
    cpu.put(8'h8A, 8'hFF);
    cpu.put(8'h8C, 8'hFF);
    cpu.put(8'h88, 8'h10);
    pulse(0);
    chk1(irq, 1'b1);
    rchk(8'h8A, 8'h00);
    rchk(8'h8C, 8'h00);
    rbit(8'h88, 5, 1'b1);
    chk1(int_req[0], 1'b1);
    rchk(8'hA0, 8'h01);
    chk1(irq, 1'b0);
    cpu.ack(0);
    rbit(8'h88, 5, 1'b0);
    $display("test overflow done");
  endtask : t_ovf

  task automatic t_reload;
    cpu.put(8'h88, 8'h00);
    cpu.put(8'h89, 8'h66);
    cpu.put(8'h8C, 8'hE0);
    cpu.put(8'h8A, 8'hFF);
    cpu.put(8'h8D, 8'hF0);
    cpu.put(8'h8B, 8'hFF);
    cpu.put(8'h88, 8'h40);
    pulse(1);
    rchk(8'h8B, 8'hF0);
    rchk(8'h8D, 8'hF0);
    rbit(8'h88, 7, 1'b1);
    chk1(irq, 1'b0);
    cpu.put(8'h88, 8'h40);
    rbit(8'h88, 7, 1'b0);
    cpu.put(8'h88, 8'h50);
    pulse(0);
    rchk(8'h8A, 8'hE0);
    rbit(8'h88, 5, 1'b1);
    $display("test reload done");
  endtask : t_reload

  task automatic t_mode0;
    cpu.put(8'h88, 8'h00);
    cpu.put(8'h89, 8'h04);
    cpu.put(8'h8A, 8'hFF);
    cpu.put(8'h8C, 8'hFF);
    cpu.put(8'h88, 8'h10);
    pulse(0);
    rchk(8'h8A, 8'hE0);
    rchk(8'h8C, 8'h00);
    rbit(8'h88, 5, 1'b1);
    pulse(0);
    rchk(8'h8A, 8'hE1);
    rchk(8'h8C, 8'h00);
    $display("test mode0 done");
  endtask : t_mode0

  task automatic t_split;
    cpu.put(8'h88, 8'h00);
    cpu.put(8'h89, 8'h57);
    cpu.put(8'h8A, 8'h10);
    cpu.put(8'h8C, 8'h00);
    cpu.put(8'h8B, 8'h20);
    cpu.put(8'h88, 8'h10);
    pulse(0);
    pulse(1);
    rchk(8'h8A, 8'h11);
    rchk(8'h8B, 8'h21);
    repeat (40) @(posedge clk);
    rchk(8'h8C, 8'h00);
    cpu.put(8'h8C, 8'hFE);
    cpu.put(8'h88, 8'h50);
    repeat (40) @(posedge clk);
    cpu.get(8'h8C, rv);
    chk1(rv != 8'h00, 1'b1);
    rbit(8'h88, 7, 1'b1);
    cpu.ack(1);
    rbit(8'h88, 7, 1'b0);
    cpu.put(8'h89, 8'h75);
    pulse(1);
    rchk(8'h8B, 8'h21);
    $display("test split done");
  endtask : t_split

  task automatic t_irq;
    cpu.put(8'h88, 8'h01);
    cpu.get(8'hA0, rv);
    cpu.put(8'hA1, 8'h04);
    pulse(2);
    rbit(8'h88, 1, 1'b1);
    chk1(irq, 1'b1);
    chk1(int_req[2], 1'b1);
    cpu.ack(2);
    rbit(8'h88, 1, 1'b0);
    cpu.put(8'h88, 8'h00);
    pins[3] <= 1'b0;
    repeat (3) @(posedge clk);
    rbit(8'h88, 3, 1'b1);
    pins[3] <= 1'b1;
    repeat (3) @(posedge clk);
    rbit(8'h88, 3, 1'b0);
    $display("test irq done");
  endtask : t_irq

  // ----------------------------------------------------------------
  // Sequence and timeout
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      close_out();
    end
  end

  initial begin
    arst_n = 1'b0;
    pins = 4'hF;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_rw();
    t_run_gate();
    t_ovf();
    t_reload();
    t_mode0();
    t_split();
    t_irq();
    close_out();
  end
endmodule : tb_top
